// ===== hw/dpc_pll_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_pll_ctrl_regs
  import dpc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          spi_clk_pin,
  input  wire logic          spi_sel_n_pin,
  input  wire logic          spi_din_pin,
  output var  logic          spi_dout,
  output var  logic          spi_dout_oe_n,
  output var  logic          first_loop_enable,
  output var  logic          first_loop_bypass,
  output var  logic          synth_loop_enable,
  output var  logic          synth_loop_bypass,
  output var  logic          oscillator_range_choice,
  output var  logic          oscillator_sense_invert,
  output var  logic          force_mid_control_voltage,
  output var  logic [4:0]    first_loop_pump_code,
  output var  logic [10:0]   first_loop_pump_ua,
  output var  logic [4:0]    synth_loop_pump_code,
  output var  logic [12:0]   synth_loop_pump_ua,
  output var  logic          phase_skew_enable,
  output var  logic [4:0]    first_loop_phase_skew_code,
  output var  logic [8:0]    phase_skew_tenth_deg
);
  dpc_cfg_if          cfg ();

  logic               first_bypass_reg;
  logic               synth_bypass_reg;
  logic               range_reg;
  logic               sense_inv_reg;
  logic               force_mid_reg;
  logic [4:0]         first_pump_reg;
  logic               skew_en_reg;
  logic [4:0]         skew_code_reg;
  logic [4:0]         synth_pump_reg;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [12:0] pump_ua(
    input logic [4:0] code,
    input logic [7:0] step
  );
    logic [12:0] count;
    count = {8'h00, code} + 13'h0001;
    return 13'(count * {5'h00, step});
  endfunction

  function automatic logic hit(input logic [6:0] ofs);
    return cfg.wr_stb && (cfg.addr == ofs);
  endfunction

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  dpc_spi_port u_port (
    .clk           (clk),
    .rst           (rst),
    .spi_clk_pin   (spi_clk_pin),
    .spi_sel_n_pin (spi_sel_n_pin),
    .spi_din_pin   (spi_din_pin),
    .spi_dout      (spi_dout),
    .spi_dout_oe_n (spi_dout_oe_n),
    .cfg           (cfg.port)
  );

  // ------------------------------------------------------------
  // First-loop bypass register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_bypass_reg <= RST_FIRST_BYPASS;
    end
    else if (hit(OFS_FIRST_BYPASS))
    begin
      first_bypass_reg <= cfg.wdata[BIT_FIRST_BYPASS];
    end
  end

  // ------------------------------------------------------------
  // Synthesizer bypass and range register
  // ------------------------------------------------------------
  // Range value 1 is stored as written; nothing here blocks misuse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      synth_bypass_reg <= RST_SYNTH_BYPASS;
      range_reg        <= RST_RANGE;
    end
    else if (hit(OFS_SYNTH_RANGE))
    begin
      synth_bypass_reg <= cfg.wdata[BIT_SYNTH_BYPASS];
      range_reg        <= cfg.wdata[BIT_RANGE];
    end
  end

  // ------------------------------------------------------------
  // Polarity, force and first pump register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sense_inv_reg  <= RST_SENSE_INV;
      force_mid_reg  <= RST_FORCE_MID;
      first_pump_reg <= RST_FIRST_PUMP;
    end
    else if (hit(OFS_POL_PUMP))
    begin
      sense_inv_reg  <= cfg.wdata[BIT_SENSE_INV];
      force_mid_reg  <= cfg.wdata[BIT_FORCE_MID];
      first_pump_reg <= cfg.wdata[CODE_LSB +: CODE_W];
    end
  end

  // ------------------------------------------------------------
  // Phase skew register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      skew_en_reg   <= RST_SKEW_EN;
      skew_code_reg <= RST_SKEW_CODE;
    end
    else if (hit(OFS_SKEW))
    begin
      skew_en_reg   <= cfg.wdata[BIT_SKEW_EN];
      skew_code_reg <= cfg.wdata[CODE_LSB +: CODE_W];
    end
  end

  // ------------------------------------------------------------
  // Synthesizer pump register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      synth_pump_reg <= RST_SYNTH_PUMP;
    end
    else if (hit(OFS_SYNTH_PUMP))
    begin
      synth_pump_reg <= cfg.wdata[CODE_LSB +: CODE_W];
    end
  end

  // ------------------------------------------------------------
  // Read back
  // ------------------------------------------------------------
  // Unused positions stay zero; unmapped offsets read all zero
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (cfg.addr)
      OFS_FIRST_BYPASS:
      begin
        rdata_next[BIT_FIRST_BYPASS] = first_bypass_reg;
      end
      OFS_SYNTH_RANGE:
      begin
        rdata_next[BIT_SYNTH_BYPASS] = synth_bypass_reg;
        rdata_next[BIT_RANGE]        = range_reg;
      end
      OFS_POL_PUMP:
      begin
        rdata_next[BIT_SENSE_INV]         = sense_inv_reg;
        rdata_next[BIT_FORCE_MID]         = force_mid_reg;
        rdata_next[CODE_LSB +: CODE_W]    = first_pump_reg;
      end
      OFS_SKEW:
      begin
        rdata_next[BIT_SKEW_EN]           = skew_en_reg;
        rdata_next[CODE_LSB +: CODE_W]    = skew_code_reg;
      end
      OFS_SYNTH_PUMP:
      begin
        rdata_next[CODE_LSB +: CODE_W]    = synth_pump_reg;
      end
      default:
      begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Snapshot on the address strobe so shifting out sees a stable byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 8'h00;
    end
    else if (cfg.rd_stb)
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign cfg.rdata = rdata_reg;

  // ------------------------------------------------------------
  // Loop enables and routing
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_loop_enable <= ~RST_FIRST_BYPASS;
      first_loop_bypass <= RST_FIRST_BYPASS;
      synth_loop_enable <= ~RST_SYNTH_BYPASS;
      synth_loop_bypass <= RST_SYNTH_BYPASS;
    end
    else
    begin
      first_loop_enable <= ~first_bypass_reg;
      first_loop_bypass <= first_bypass_reg;
      synth_loop_enable <= ~synth_bypass_reg;
      synth_loop_bypass <= synth_bypass_reg;
    end
  end

  // ------------------------------------------------------------
  // Oscillator controls
  // ------------------------------------------------------------
  // The force level drives the tune pin clamp in the analog section
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oscillator_range_choice   <= RST_RANGE;
      oscillator_sense_invert   <= RST_SENSE_INV;
      force_mid_control_voltage <= RST_FORCE_MID;
    end
    else
    begin
      oscillator_range_choice   <= range_reg;
      oscillator_sense_invert   <= sense_inv_reg;
      force_mid_control_voltage <= force_mid_reg;
    end
  end

  // ------------------------------------------------------------
  // Charge pump codes and currents
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_loop_pump_code <= RST_FIRST_PUMP;
      first_loop_pump_ua   <= RST_FIRST_UA;
      synth_loop_pump_code <= RST_SYNTH_PUMP;
      synth_loop_pump_ua   <= RST_SYNTH_UA;
    end
    else
    begin
      first_loop_pump_code <= first_pump_reg;
      first_loop_pump_ua   <=
        11'(pump_ua(first_pump_reg, FIRST_STEP_UA));
      synth_loop_pump_code <= synth_pump_reg;
      synth_loop_pump_ua   <= pump_ua(synth_pump_reg, SYNTH_STEP_UA);
    end
  end

  // ------------------------------------------------------------
  // Phase skew to the detector
  // ------------------------------------------------------------
  // Zero code when disabled avoids offset current noise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_skew_enable          <= RST_SKEW_EN;
      first_loop_phase_skew_code <= 5'h00;
      phase_skew_tenth_deg       <= 9'h000;
    end
    else
    begin
      phase_skew_enable          <= skew_en_reg;
      first_loop_phase_skew_code <= skew_en_reg ? skew_code_reg : 5'h00;
      phase_skew_tenth_deg       <= skew_en_reg ?
        9'({4'h0, skew_code_reg} * {5'h00, SKEW_STEP_TD}) : 9'h000;
    end
  end
endmodule // dpc_pll_ctrl_regs
`default_nettype wire

// ===== hw/dpc_spi_port.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_spi_port
  import dpc_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   spi_clk_pin,
  input  wire logic   spi_sel_n_pin,
  input  wire logic   spi_din_pin,
  output var  logic   spi_dout,
  output var  logic   spi_dout_oe_n,
  dpc_cfg_if.port     cfg
);
  logic [2:0]        meta_reg;
  logic [2:0]        sync_reg;
  logic              sclk_prev_reg;
  logic              rise;
  logic              fall;
  dpc_phase_type     phase_reg;
  logic [3:0]        cnt_reg;
  logic [6:0]        shift_reg;
  logic              is_read_reg;
  logic              load_pend_reg;
  logic [7:0]        out_reg;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Idle pin levels: deselected, serial clock low, so no false edge follows reset
      meta_reg      <= 3'h4;
      sync_reg      <= 3'h4;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg      <= {spi_sel_n_pin, spi_clk_pin, spi_din_pin};
      sync_reg      <= meta_reg;
      sclk_prev_reg <= sync_reg[1];
    end
  end

  assign rise = sync_reg[1] & ~sclk_prev_reg;
  assign fall = ~sync_reg[1] & sclk_prev_reg;

  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg   <= PH_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 7'h00;
      is_read_reg <= 1'b0;
      cfg.addr    <= '0;
      cfg.wdata   <= '0;
      cfg.wr_stb  <= 1'b0;
      cfg.rd_stb  <= 1'b0;
    end
    else
    begin
      cfg.wr_stb <= 1'b0;
      cfg.rd_stb <= 1'b0;
      if (sync_reg[2])
      begin
        // Early deselect drops the frame
        phase_reg <= PH_IDLE;
        cnt_reg   <= 4'h0;
      end
      else
      begin
        unique case (phase_reg)
          PH_IDLE: phase_reg <= PH_HEAD;
          PH_HEAD:
            if (rise)
            begin
              shift_reg <= {shift_reg[5:0], sync_reg[0]};
              cnt_reg   <= cnt_reg + 4'h1;
              if (cnt_reg == 4'(HEAD_LAST))
              begin
                phase_reg   <= PH_DATA;
                is_read_reg <= shift_reg[6];
                cfg.addr    <= {shift_reg[5:0], sync_reg[0]};
                cfg.rd_stb  <= shift_reg[6];
              end
            end
          PH_DATA:
            if (rise)
            begin
              shift_reg <= {shift_reg[5:0], sync_reg[0]};
              cnt_reg   <= cnt_reg + 4'h1;
              if (cnt_reg == 4'(FRAME_LAST))
              begin
                phase_reg  <= PH_DONE;
                cfg.wdata  <= {shift_reg, sync_reg[0]};
                cfg.wr_stb <= ~is_read_reg;
              end
            end
          PH_DONE: phase_reg <= PH_DONE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Read data out, changed on falling serial clock
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_pend_reg <= 1'b0;
      out_reg       <= 8'h00;
      spi_dout_oe_n <= 1'b1;
    end
    else if (sync_reg[2])
    begin
      load_pend_reg <= 1'b0;
      spi_dout_oe_n <= 1'b1;
    end
    else if (cfg.rd_stb)
    begin
      load_pend_reg <= 1'b1;
    end
    else if (fall && phase_reg == PH_DATA && is_read_reg)
    begin
      load_pend_reg <= 1'b0;
      spi_dout_oe_n <= 1'b0;
      out_reg       <= load_pend_reg ? cfg.rdata : {out_reg[6:0], 1'b0};
    end
  end

  assign spi_dout = out_reg[7];
endmodule // dpc_spi_port
`default_nettype wire

// ===== inc/dpc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpc_cfg_if;
  logic                          wr_stb;
  logic                          rd_stb;
  logic [dpc_pkg::ADDR_W-1:0]    addr;
  logic [dpc_pkg::DATA_W-1:0]    wdata;
  logic [dpc_pkg::DATA_W-1:0]    rdata;

  modport port (output wr_stb, rd_stb, addr, wdata, input rdata);
  modport regs (input wr_stb, rd_stb, addr, wdata, output rdata);
endinterface
`default_nettype wire

// ===== inc/dpc_pkg.sv
`default_nettype none
package dpc_pkg;
  // ------------------------------------------------------------
  // Serial frame
  // ------------------------------------------------------------
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 8;
  localparam int CODE_W     = 5;
  localparam int HEAD_LAST  = 7;
  localparam int FRAME_LAST = 15;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HEAD = 2'b01,
    PH_DATA = 2'b10,
    PH_DONE = 2'b11
  } dpc_phase_type;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] OFS_FIRST_BYPASS = 7'h17;
  localparam logic [6:0] OFS_SYNTH_RANGE  = 7'h18;
  localparam logic [6:0] OFS_POL_PUMP     = 7'h1c;
  localparam logic [6:0] OFS_SKEW         = 7'h1d;
  localparam logic [6:0] OFS_SYNTH_PUMP   = 7'h1e;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_FIRST_BYPASS = 0;
  localparam int BIT_RANGE        = 0;
  localparam int BIT_SYNTH_BYPASS = 1;
  localparam int BIT_SENSE_INV    = 7;
  localparam int BIT_FORCE_MID    = 6;
  localparam int BIT_SKEW_EN      = 5;
  localparam int CODE_LSB         = 0;

  // ------------------------------------------------------------
  // Reset values and scale factors
  // ------------------------------------------------------------
  localparam logic       RST_FIRST_BYPASS = 1'b0;
  localparam logic       RST_SYNTH_BYPASS = 1'b0;
  localparam logic       RST_RANGE        = 1'b0;
  localparam logic       RST_SENSE_INV    = 1'b0;
  localparam logic       RST_FORCE_MID    = 1'b1;
  localparam logic       RST_SKEW_EN      = 1'b0;
  localparam logic [4:0] RST_FIRST_PUMP   = 5'h0f;
  localparam logic [4:0] RST_SYNTH_PUMP   = 5'h06;
  localparam logic [4:0] RST_SKEW_CODE    = 5'h00;

  localparam logic [7:0] FIRST_STEP_UA = 8'h32;
  localparam logic [7:0] SYNTH_STEP_UA = 8'hc8;
  localparam logic [3:0] SKEW_STEP_TD  = 4'h9;

  localparam logic [10:0] RST_FIRST_UA =
    11'((RST_FIRST_PUMP + 1) * FIRST_STEP_UA);
  localparam logic [12:0] RST_SYNTH_UA =
    13'((RST_SYNTH_PUMP + 1) * SYNTH_STEP_UA);
endpackage
`default_nettype wire

// ===== sim/dpc_pll_ctrl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_pll_ctrl_regs_monitor
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        spi_sel_n_pin,
  input wire logic        spi_dout_oe_n,
  input wire logic        first_loop_enable,
  input wire logic        first_loop_bypass,
  input wire logic        synth_loop_enable,
  input wire logic        synth_loop_bypass,
  input wire logic        oscillator_range_choice,
  input wire logic        oscillator_sense_invert,
  input wire logic        force_mid_control_voltage,
  input wire logic [4:0]  first_loop_pump_code,
  input wire logic [10:0] first_loop_pump_ua,
  input wire logic [4:0]  synth_loop_pump_code,
  input wire logic [12:0] synth_loop_pump_ua,
  input wire logic        phase_skew_enable,
  input wire logic [4:0]  first_loop_phase_skew_code,
  input wire logic [8:0]  phase_skew_tenth_deg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  first_en_inv_a: assert property (first_loop_enable == !first_loop_bypass)
    else $error("first loop enable disagrees with bypass");
  synth_en_inv_a: assert property (synth_loop_enable == !synth_loop_bypass)
    else $error("second loop enable disagrees with bypass");
  first_pump_ua_a: assert property
    (first_loop_pump_ua == (11'(first_loop_pump_code) + 11'd1) * 11'd50)
    else $error("first pump current wrong for code");
  synth_pump_ua_a: assert property
    (synth_loop_pump_ua == (13'(synth_loop_pump_code) + 13'd1) * 13'd200)
    else $error("second pump current wrong for code");
  skew_off_a: assert property
    (!phase_skew_enable |-> first_loop_phase_skew_code == 5'h00 && phase_skew_tenth_deg == 9'h000)
    else $error("skew applied while disabled");
  skew_deg_a: assert property
    (phase_skew_tenth_deg == 9'(first_loop_phase_skew_code) * 9'd9)
    else $error("skew angle wrong for code");
  reset_codes_a: assert property ($fell(rst) |-> force_mid_control_voltage
    && first_loop_pump_code == 5'h0f && synth_loop_pump_code == 5'h06)
    else $error("code fields wrong after reset");
  reset_bits_a: assert property ($fell(rst) |-> !first_loop_bypass
    && !synth_loop_bypass && !oscillator_range_choice && !oscillator_sense_invert
    && !phase_skew_enable)
    else $error("control bits wrong after reset");
  // Idle port must never disturb stored fields
  idle_stable_a: assert property (spi_sel_n_pin [*8] |=>
    $stable(first_loop_pump_code) && $stable(synth_loop_pump_code)
    && $stable(force_mid_control_voltage))
    else $error("field changed with no frame");
  oe_release_a: assert property (spi_sel_n_pin [*6] |-> spi_dout_oe_n)
    else $error("data output still driven after deselect");
endmodule // dpc_pll_ctrl_regs_monitor

bind dpc_pll_ctrl_regs dpc_pll_ctrl_regs_monitor mon
(
  .clk, .rst, .spi_sel_n_pin, .spi_dout_oe_n, .first_loop_enable, .first_loop_bypass,
  .synth_loop_enable, .synth_loop_bypass, .oscillator_range_choice,
  .oscillator_sense_invert, .force_mid_control_voltage, .first_loop_pump_code,
  .first_loop_pump_ua, .synth_loop_pump_code, .synth_loop_pump_ua, .phase_skew_enable,
  .first_loop_phase_skew_code, .phase_skew_tenth_deg
);
`default_nettype wire

// ===== sim/dual_pll_control_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_pll_control_regs_tb_top
  import dpc_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        spi_clk_pin;
  logic        spi_sel_n_pin;
  logic        spi_din_pin;
  logic        spi_dout;
  logic        spi_dout_oe_n;
  logic        first_loop_enable;
  logic        first_loop_bypass;
  logic        synth_loop_enable;
  logic        synth_loop_bypass;
  logic        oscillator_range_choice;
  logic        oscillator_sense_invert;
  logic        force_mid_control_voltage;
  logic [4:0]  first_loop_pump_code;
  logic [10:0] first_loop_pump_ua;
  logic [4:0]  synth_loop_pump_code;
  logic [12:0] synth_loop_pump_ua;
  logic        phase_skew_enable;
  logic [4:0]  first_loop_phase_skew_code;
  logic [8:0]  phase_skew_tenth_deg;
  int          n_fail;
  int          checks_done;
  int          cyc;

  dpc_pll_ctrl_regs dut
  (
    .clk, .rst, .spi_clk_pin, .spi_sel_n_pin, .spi_din_pin, .spi_dout, .spi_dout_oe_n,
    .first_loop_enable, .first_loop_bypass, .synth_loop_enable, .synth_loop_bypass,
    .oscillator_range_choice, .oscillator_sense_invert, .force_mid_control_voltage,
    .first_loop_pump_code, .first_loop_pump_ua, .synth_loop_pump_code,
    .synth_loop_pump_ua, .phase_skew_enable, .first_loop_phase_skew_code,
    .phase_skew_tenth_deg
  );

  always #20 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_sim;
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Every full 16-bit frame takes about 300 cycles; the whole run stays far below this
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Serial phases of 8 cycles leave margin over the 6-cycle minimum
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input int nb, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge clk);
    spi_sel_n_pin <= 1'b0;
    for (int i = 15; i > 15 - nb; i--)
    begin
      spi_din_pin <= f[i];
      wt(8);
      spi_clk_pin <= 1'b1;
      if (i < 8)
        q[i] = spi_dout;
      chk(spi_dout_oe_n, !(rd && i < 8));
      wt(8);
      spi_clk_pin <= 1'b0;
    end
    wt(8);
    spi_sel_n_pin <= 1'b1;
    spi_din_pin <= ~spi_din_pin;
    wt(16);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, 16, q);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b1, a, 8'h00, 16, q);
    chk(q, e);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults;
    chk(first_loop_enable, 1'b1);
    chk(synth_loop_bypass, 1'b0);
    chk(synth_loop_enable, 1'b1);
    chk(first_loop_pump_ua, 11'd800);
    chk(synth_loop_pump_ua, 13'd1400);
    chk(first_loop_phase_skew_code, 5'h00);
    rdchk(OFS_FIRST_BYPASS, 8'h00);
    rdchk(OFS_SYNTH_RANGE, 8'h00);
    rdchk(OFS_POL_PUMP, 8'h4f);
    rdchk(OFS_SKEW, 8'h00);
    rdchk(OFS_SYNTH_PUMP, 8'h06);
  endtask

  task automatic t_bypass;
    wr(OFS_FIRST_BYPASS, 8'hff);
    chk(first_loop_enable, 1'b0);
    rdchk(OFS_FIRST_BYPASS, 8'h01);
    wr(OFS_SYNTH_RANGE, 8'hfe);
    chk(synth_loop_bypass, 1'b1);
    chk(synth_loop_enable, 1'b0);
    chk(oscillator_range_choice, 1'b0);
    rdchk(OFS_SYNTH_RANGE, 8'h02);
    wr(OFS_SYNTH_RANGE, 8'h00);
    chk(oscillator_range_choice, 1'b0);
    chk(synth_loop_enable, 1'b1);
    rdchk(OFS_SYNTH_RANGE, 8'h00);
    wr(OFS_FIRST_BYPASS, 8'h00);
    chk(first_loop_bypass, 1'b0);
  endtask

  task automatic t_first_pump;
    wr(OFS_POL_PUMP, 8'h1f);
    chk(force_mid_control_voltage, 1'b0);
    chk(first_loop_pump_ua, 11'd1600);
    chk(oscillator_sense_invert, 1'b0);
    wr(OFS_POL_PUMP, 8'ha0);
    chk(oscillator_sense_invert, 1'b1);
    chk(first_loop_pump_ua, 11'd50);
    rdchk(OFS_POL_PUMP, 8'h80);
    wr(OFS_POL_PUMP, 8'h40);
    chk(force_mid_control_voltage, 1'b1);
  endtask

  task automatic t_skew;
    wr(OFS_SKEW, 8'h1f);
    chk(phase_skew_tenth_deg, 9'd0);
    wr(OFS_SKEW, 8'hff);
    chk(phase_skew_enable, 1'b1);
    chk(phase_skew_tenth_deg, 9'd279);
    rdchk(OFS_SKEW, 8'h3f);
    wr(OFS_SKEW, 8'h21);
    chk(phase_skew_tenth_deg, 9'd9);
  endtask

  task automatic t_synth_pump;
    logic [7:0] q;
    wr(OFS_SYNTH_PUMP, 8'hff);
    chk(synth_loop_pump_ua, 13'd6400);
    rdchk(OFS_SYNTH_PUMP, 8'h1f);
    wr(OFS_SYNTH_PUMP, 8'h00);
    chk(synth_loop_pump_ua, 13'd200);
    xfer(1'b0, OFS_SYNTH_PUMP, 8'h0a, 10, q);
    chk(synth_loop_pump_code, 5'h00);
    wr(7'h19, 8'hff);
    rdchk(7'h19, 8'h00);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    clk = 1'b0;
    rst = 1'b1;
    spi_clk_pin = 1'b0;
    spi_sel_n_pin = 1'b1;
    spi_din_pin = 1'b0;
    wt(10);
    rst <= 1'b0;
    wt(4);
    t_defaults;
    t_bypass;
    t_first_pump;
    t_skew;
    t_synth_pump;
    // Mid-run reset must restore every field
    rst <= 1'b1;
    wt(10);
    rst <= 1'b0;
    wt(4);
    t_defaults;
    end_sim;
  end
endmodule // dual_pll_control_regs_tb_top
`default_nettype wire
